// ==== pkg/reset_entry_pkg.sv ====
// Package with constants and types shared by the reset and clock entry logic.
package reset_entry_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int FAST_POR_DELAY_NS = 1000;
	localparam int STD_POR_DELAY_NS = 100000;
	localparam int FAST_POR_CYCLES = (FAST_POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STD_POR_CYCLES = (STD_POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WARM_HOLD_NS = 800;
	localparam int WARM_HOLD_CYCLES = (WARM_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2;
	localparam int CNT_WIDTH = 24;
	localparam logic [1:0] SYNC_RESET_VALUE = 2'h0;
	typedef enum logic [1:0] {
		ST_COLD = 2'h0,
		ST_POR_WAIT = 2'h1,
		ST_RUN = 2'h3,
		ST_WARM = 2'h2
	} seq_state_type;
endpackage : reset_entry_pkg

// ==== pkg/reset_sync_if.sv ====
// Interface carrying synchronised reset levels between the entry modules.
`timescale 1ns/1ps
interface reset_sync_if;
	logic coldAsync;
	logic warmAsync;
	logic coldSync;
	logic warmSync;
	modport syncer (input coldAsync, input warmAsync, output coldSync, output warmSync);
	modport user (output coldAsync, output warmAsync, input coldSync, input warmSync);
endinterface : reset_sync_if

// ==== test/board_supervisor_model.sv ====
// Board supervisor sharing the open-drain warm reset line with a pull-up.
`timescale 1ns/1ps
module board_supervisor_model (
	input wire logic pullLow,
	input wire logic dutOe,
	output logic pinLevel
);
	assign pinLevel = !(pullLow || !dutOe);
endmodule : board_supervisor_model

// ==== test/reset_entry_props.sv ====
// Port checker for the reset and clock entry block.
`timescale 1ns/1ps
module reset_entry_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic coldResetN,
	input wire logic warmResetNIn,
	input wire logic warmResetNOut,
	input wire logic warmResetNOe,
	input wire logic swWarmReq,
	input wire logic coldResetActive,
	input wire logic warmResetActive,
	input wire logic tapResetN,
	input wire logic primaryRefClockIn,
	input wire logic mainPllRef
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_tap; tapResetN == !coldResetActive; endproperty
	a_tap: assert property (p_tap) else $error("tap reset wrong");
	property p_odat; warmResetNOut == 1'b0; endproperty
	a_odat: assert property (p_odat) else $error("pin driven high");
	property p_cold; !coldResetN |-> ##[1:5] coldResetActive; endproperty
	a_cold: assert property (p_cold) else $error("cold not taken");
	property p_sw; !warmResetActive && swWarmReq |=> !warmResetNOe && warmResetActive; endproperty
	a_sw: assert property (p_sw) else $error("warm request missed");
	property p_ext; !warmResetActive && !warmResetNIn |-> ##[1:4] warmResetActive; endproperty
	a_ext: assert property (p_ext) else $error("pin reset missed");
	property p_hold; $fell(swWarmReq) && !warmResetNOe |-> ##98 !warmResetNOe; endproperty
	a_hold: assert property (p_hold) else $error("pin released early");
	property p_main; mainPllRef == primaryRefClockIn; endproperty
	a_main: assert property (p_main) else $error("main ref wrong");
	property p_run; $fell(coldResetActive) |-> $fell(warmResetActive); endproperty
	a_run: assert property (p_run) else $error("cold exit wrong");
	c_warm: cover property (!warmResetNOe);
	c_exit: cover property ($fell(coldResetActive));
	c_ext: cover property (!warmResetNIn && warmResetNOe);
endmodule : reset_entry_props
bind subsystem_reset_clock_entry reset_entry_props chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.coldResetN(coldResetN), .warmResetNIn(warmResetNIn), .warmResetNOut(warmResetNOut),
	.warmResetNOe(warmResetNOe), .swWarmReq(swWarmReq), .coldResetActive(coldResetActive),
	.warmResetActive(warmResetActive), .tapResetN(tapResetN),
	.primaryRefClockIn(primaryRefClockIn), .mainPllRef(mainPllRef));

// ==== test/subsystem_reset_clock_entry_tb_top.sv ====
// Self-checking bench for the reset and clock entry block.
`timescale 1ns/1ps
module subsystem_reset_clock_entry_tb_top;
	logic ref_clk = 0, sys_rst = 1, coldN = 0, sel = 1, pull = 0;
	logic [4:0] req = 5'h0;
	logic [5:0] mux = 6'h0;
	logic pin, oeN, odat, cAct, wAct, tapN, mainR, perR, memR;
	int error_cnt = 0, num_checks = 0, cyc = 0, n, f;
	always #4 ref_clk = !ref_clk;
	board_supervisor_model sup_u (.pullLow(pull), .dutOe(oeN), .pinLevel(pin));
	subsystem_reset_clock_entry #(.STD_DELAY(20), .FAST_DELAY(5)) dut_u (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .primaryRefClockIn(mux[0]), .alternateRefClockIn(mux[1]),
		.coldResetN(coldN), .porDelaySelect(sel), .warmResetNIn(pin), .warmResetNOut(odat),
		.warmResetNOe(oeN), .swWarmReq(req[0]), .fabricWarmReq(req[1]), .debugWarmReq(req[2]),
		.swColdReq(req[3]), .fabricColdReq(req[4]), .periphUseAlt(mux[2]), .memUseAlt(mux[4]),
		.periphUsePrimary(mux[5]), .memUsePrimary(mux[3]), .mainPllRef(mainR),
		.periphPllRef(perR), .memPllRef(memR), .coldResetActive(cAct),
		.warmResetActive(wAct), .tapResetN(tapN));
	task step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : step
	task chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %b", $time, got);
		end
	endtask : chk
	task close_out;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task settle(output int k);
		k = 0;
		while (wAct !== 1'b0 && k < 400) begin
			step(1);
			k++;
		end
		chk(wAct, 1'b0);
	endtask : settle
	task cold(input logic s, output int k);
		coldN = 0;
		sel = s;
		step(8);
		chk(tapN, 1'b0);
		chk(cAct, 1'b1);
		coldN = 1;
		settle(k);
	endtask : cold
	task warm_reqs;
		for (int i = 0; i < 5; i++) begin
			req[i] = 1;
			step(2);
			if (i < 3) chk(pin, 1'b0);
			else chk(cAct, 1'b1);
			req[i] = 0;
			settle(n);
		end
	endtask : warm_reqs
	task ext_warm;
		pull = 1;
		step(20);
		chk(wAct, 1'b1);
		chk(oeN, 1'b1);
		pull = 0;
		settle(n);
	endtask : ext_warm
	task clocks;
		for (int i = 0; i < 64; i++) begin
			mux = i[5:0];
			step(1);
			chk(mainR, mux[0]);
			chk(perR, mux[2] ? mux[1] : (mux[5] & mux[0]));
			chk(memR, mux[4] ? mux[1] : (mux[3] & mux[0]));
		end
	endtask : clocks
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		step(16);
		sys_rst = 0;
		cold(1'b1, f);
		cold(1'b0, n);
		chk(n - f == 20 - 5, 1'b1);
		warm_reqs();
		ext_warm();
		clocks();
		close_out();
	end
endmodule : subsystem_reset_clock_entry_tb_top

// ==== verilog/reset_input_sync.sv ====
// Two-stage synchronisers for the external cold and warm reset requests.
`timescale 1ns/1ps
module reset_input_sync
	import reset_entry_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	reset_sync_if.syncer rs
);
	logic [1:0] coldSync_reg;
	logic [1:0] coldSync_next;
	logic [1:0] warmSync_reg;
	logic [1:0] warmSync_next;

	always_comb begin
		coldSync_next = {coldSync_reg[0], rs.coldAsync};
		warmSync_next = {warmSync_reg[0], rs.warmAsync};
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			coldSync_reg <= SYNC_RESET_VALUE;
			warmSync_reg <= SYNC_RESET_VALUE;
		end else begin
			coldSync_reg <= coldSync_next;
			warmSync_reg <= warmSync_next;
		end
	end

	assign rs.coldSync = coldSync_reg[1];
	assign rs.warmSync = warmSync_reg[1];
endmodule : reset_input_sync

// ==== verilog/subsystem_reset_clock_entry.sv ====
// Cold and warm reset sequencing and PLL reference selection for the subsystem.
`timescale 1ns/1ps
module subsystem_reset_clock_entry
	import reset_entry_pkg::*;
#(
	parameter int STD_DELAY = STD_POR_CYCLES,
	parameter int FAST_DELAY = FAST_POR_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic primaryRefClockIn,
	input wire logic alternateRefClockIn,
	input wire logic coldResetN,
	input wire logic porDelaySelect,
	input wire logic warmResetNIn,
	output logic warmResetNOut,
	output logic warmResetNOe,
	input wire logic swWarmReq,
	input wire logic swColdReq,
	input wire logic fabricWarmReq,
	input wire logic fabricColdReq,
	input wire logic debugWarmReq,
	input wire logic periphUseAlt,
	input wire logic memUseAlt,
	input wire logic periphUsePrimary,
	input wire logic memUsePrimary,
	output logic mainPllRef,
	output logic periphPllRef,
	output logic memPllRef,
	output logic coldResetActive,
	output logic warmResetActive,
	output logic tapResetN
);
	reset_sync_if rs ();

	seq_state_type state_reg;
	seq_state_type state_next;
	logic [CNT_WIDTH-1:0] count_reg;
	logic [CNT_WIDTH-1:0] count_next;
	logic fastSel_reg;
	logic fastSel_next;
	logic drivePin_reg;
	logic drivePin_next;
	logic coldOut_reg;
	logic coldOut_next;
	logic warmOut_reg;
	logic warmOut_next;
	logic [1:0] ownEcho_reg;
	logic [1:0] ownEcho_next;
	logic coldReq;
	logic extWarm;
	logic intWarm;
	logic [CNT_WIDTH-1:0] delayCycles;
	localparam logic [CNT_WIDTH-1:0] WARM_HOLD = CNT_WIDTH'(WARM_HOLD_CYCLES);

	assign rs.coldAsync = ~coldResetN;
	// Pin low means outside warm request.
	assign rs.warmAsync = ~warmResetNIn;

	reset_input_sync u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.rs(rs)
	);

	// Internal cold sources merge with the pin.
	assign coldReq = rs.coldSync | swColdReq | fabricColdReq;
	// Debugger warm request joins internal sources.
	assign intWarm = swWarmReq | fabricWarmReq | debugWarmReq;
	// Our own drive reads back as low, so ignore the pin while we pull it.
	// The synchroniser still shows that low for two edges after release,
	// so the echo of our drive is masked as well, or we would re-enter warm reset.
	assign extWarm = rs.warmSync & ~drivePin_reg & ~(|ownEcho_reg);
	// Delay chosen by the sampled strap.
	assign delayCycles = fastSel_reg ? CNT_WIDTH'(FAST_DELAY) : CNT_WIDTH'(STD_DELAY);

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		fastSel_next = fastSel_reg;
		drivePin_next = drivePin_reg;
		ownEcho_next = {ownEcho_reg[0], drivePin_reg};
		case (state_reg)
			ST_COLD: begin
				count_next = '0;
				drivePin_next = 1'b0;
				// The strap is caught while cold reset holds, never by the reset itself.
				fastSel_next = porDelaySelect;
				if (!coldReq) begin
					state_next = ST_POR_WAIT;
				end
			end
			ST_POR_WAIT: begin
				if (coldReq) begin
					state_next = ST_COLD;
				end else if (count_reg >= delayCycles - 1'b1) begin
					state_next = ST_RUN;
					count_next = '0;
				end else begin
					count_next = count_reg + 1'b1;
				end
			end
			ST_RUN: begin
				count_next = '0;
				if (coldReq) begin
					state_next = ST_COLD;
				end else if (intWarm) begin
					state_next = ST_WARM;
					drivePin_next = 1'b1;
				end else if (extWarm) begin
					state_next = ST_WARM;
					drivePin_next = 1'b0;
				end
			end
			ST_WARM: begin
				if (coldReq) begin
					state_next = ST_COLD;
				end else if (intWarm || extWarm) begin
					count_next = '0;
					// An inside request during an outside reset drives the pin too.
					if (intWarm) begin
						drivePin_next = 1'b1;
					end
				end else if (count_reg >= WARM_HOLD - 1'b1) begin
					state_next = ST_RUN;
					count_next = '0;
					drivePin_next = 1'b0;
				end else begin
					count_next = count_reg + 1'b1;
				end
			end
			default: begin
				state_next = ST_COLD;
			end
		endcase
		coldOut_next = (state_next == ST_COLD) || (state_next == ST_POR_WAIT);
		warmOut_next = (state_next != ST_RUN);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= ST_COLD;
			count_reg <= '0;
			fastSel_reg <= 1'b0;
			drivePin_reg <= 1'b0;
			ownEcho_reg <= 2'h0;
			coldOut_reg <= 1'b1;
			warmOut_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			fastSel_reg <= fastSel_next;
			drivePin_reg <= drivePin_next;
			ownEcho_reg <= ownEcho_next;
			coldOut_reg <= coldOut_next;
			warmOut_reg <= warmOut_next;
		end
	end

	// Output data is always low; only the enable moves, low enable drives.
	assign warmResetNOut = 1'b0;
	assign warmResetNOe = ~drivePin_reg;

	assign coldResetActive = coldOut_reg;
	assign warmResetActive = warmOut_reg;
	// Test port reset through cold reset.
	assign tapResetN = ~coldOut_reg;

	assign mainPllRef = primaryRefClockIn;
	// Alternate clock may feed peripheral and memory PLLs.
	always_comb begin
		periphPllRef = 1'b0;
		memPllRef = 1'b0;
		if (periphUseAlt) begin
			periphPllRef = alternateRefClockIn;
		end else if (periphUsePrimary) begin
			periphPllRef = primaryRefClockIn;
		end
		if (memUseAlt) begin
			memPllRef = alternateRefClockIn;
		end else if (memUsePrimary) begin
			memPllRef = primaryRefClockIn;
		end
	end
endmodule : subsystem_reset_clock_entry
